// *** verilog/timer16_defines.svh ***
// Constants for the 16-bit timer: mode codes, compare actions, reset values.
// Assumes inclusion by bare name from design and bench files.
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

`define TMR_WIDTH 16
`define TMR_NCH 2
`define TMR_MAX 16'hFFFF
`define TMR_BOTTOM 16'h0000
`define TMR_ONE 16'h0001
`define WGM_NORMAL 4'h0
`define WGM_CTC_OCR 4'h4
`define WGM_CTC_ICR 4'hC
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3
`define TMR_MATCH_NONE 2'h0

`endif

// *** verilog/timer16_pkg.sv ***
// Types shared by the 16-bit timer and its compare output channel.
// Assumes timer16_defines.svh is available on the include path.
package timer16_pkg;

  typedef enum logic [2:0] {
    WAVE_NONPWM = 3'h1,
    WAVE_FAST = 3'h2,
    WAVE_PHASE = 3'h4
  } wave_class_e;

  typedef struct packed {
    logic [1:0] compare_output_mode;
    logic force_compare_strobe;
    logic [15:0] compare_value;
  } chan_cfg_s;

endpackage : timer16_pkg

// *** verilog/compare_output_channel.sv ***
// One compare output channel: holds the pin level and applies the mode action.
// Assumes the parent decodes the waveform class and provides tick-qualified match and PWM events; the force strobe is not tick-qualified.
`timescale 1ns/1ps
`include "timer16_defines.svh"

module compare_output_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] compare_output_mode,
  input wire logic match,
  input wire logic force_strobe,
  input wire logic pwm_set,
  input wire logic pwm_clr,
  input wire timer16_pkg::wave_class_e wave_class,
  output logic pin_ff
);

  logic nxt_pin;

  always_comb begin
    nxt_pin = pin_ff;
    if (wave_class == timer16_pkg::WAVE_NONPWM) begin
      if (match || force_strobe) begin
        case (compare_output_mode)
          `COM_TOGGLE: nxt_pin = ~pin_ff;
          `COM_CLEAR: nxt_pin = 1'b0;
          `COM_SET: nxt_pin = 1'b1;
          default: nxt_pin = pin_ff;
        endcase
      end
    end else begin
      // Mode 2 is non-inverted, mode 3 inverted
      if (compare_output_mode[1]) begin
        if (pwm_set) begin
          nxt_pin = ~compare_output_mode[0];
        end else if (pwm_clr) begin
          nxt_pin = compare_output_mode[0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

endmodule : compare_output_channel

// *** verilog/timer16.sv ***
// 16-bit timer/counter with normal, CTC and simple PWM sequencing and two compare outputs.
// Assumes control ports are synchronous to clk and timer_tick is a one-cycle enable.
// What this block does
// - A compare output mode of zero leaves the channel pin untouched at a compare match.
// - A new compare output mode acts from the next compare match, force strobe or fast PWM top onward.
// - In non-PWM modes the force strobe applies the configured action at once.
// - Waveform mode and compare output mode together set the behaviour; only waveform mode alters counting.
// - In PWM modes the compare output mode picks inverted or non-inverted output.
// - In non-PWM modes the compare output mode sets, clears or toggles the pin on a match.
// - In normal mode the counter only increments and is never cleared by compare or top.
// - In normal mode the counter wraps from all ones to zero and keeps counting up.
// - The overflow flag sets in the cycle the counter becomes zero after wrapping.
// - Counting only sets the overflow flag; servicing the interrupt clears it.
// - Software may write the counter value at any time.
`timescale 1ns/1ps
`include "timer16_defines.svh"

module timer16 (
  input wire logic clk,
  input wire logic rst,
  input wire logic timer_tick,
  input wire logic [3:0] waveform_gen_mode,
  input wire timer16_pkg::chan_cfg_s chan_a,
  input wire timer16_pkg::chan_cfg_s chan_b,
  input wire logic [15:0] top_value,
  input wire logic counter_write,
  input wire logic [15:0] counter_wdata,
  input wire logic overflow_ack,
  output logic [15:0] counter_value_ff,
  output logic overflow_flag_ff,
  output logic [1:0] compare_match_ff,
  output logic [1:0] compare_output_pin_ff
);

  timer16_pkg::wave_class_e wave_class;
  logic [15:0] nxt_counter;
  logic [15:0] cnt_top;
  logic clear_at_top;
  logic at_top;
  logic wrap;
  logic up_ff;
  logic nxt_up;
  logic [15:0] cmp_val [`TMR_NCH];
  logic [1:0] cmp_mode [`TMR_NCH];
  logic force_chan [`TMR_NCH];
  logic [`TMR_NCH-1:0] match;
  logic [`TMR_NCH-1:0] pin;

  assign cmp_val[0] = chan_a.compare_value;
  assign cmp_val[1] = chan_b.compare_value;
  assign cmp_mode[0] = chan_a.compare_output_mode;
  assign cmp_mode[1] = chan_b.compare_output_mode;
  assign force_chan[0] = chan_a.force_compare_strobe;
  assign force_chan[1] = chan_b.force_compare_strobe;

  // Waveform mode alone shapes the count sequence
  always_comb begin
    clear_at_top = 1'b0;
    cnt_top = `TMR_MAX;
    wave_class = timer16_pkg::WAVE_NONPWM;
    case (waveform_gen_mode)
      `WGM_NORMAL: begin
        clear_at_top = 1'b0;
        cnt_top = `TMR_MAX;
      end
      `WGM_CTC_OCR: begin
        clear_at_top = 1'b1;
        cnt_top = chan_a.compare_value;
      end
      `WGM_CTC_ICR: begin
        clear_at_top = 1'b1;
        cnt_top = top_value;
      end
      default: begin
        if (waveform_gen_mode[3] || !waveform_gen_mode[2]) begin
          wave_class = timer16_pkg::WAVE_PHASE;
        end else begin
          wave_class = timer16_pkg::WAVE_FAST;
        end
        clear_at_top = 1'b1;
        cnt_top = top_value;
      end
    endcase
  end

  assign at_top = (counter_value_ff == cnt_top);
  assign wrap = (counter_value_ff == `TMR_MAX);

  always_comb begin
    nxt_counter = counter_value_ff;
    nxt_up = up_ff;
    if (counter_write) begin
      nxt_counter = counter_wdata;
    end else if (timer_tick) begin
      if (wave_class == timer16_pkg::WAVE_PHASE) begin
        if (up_ff && at_top) begin
          nxt_up = 1'b0;
          nxt_counter = counter_value_ff - `TMR_ONE;
        end else if (!up_ff && counter_value_ff == `TMR_BOTTOM) begin
          nxt_up = 1'b1;
          nxt_counter = counter_value_ff + `TMR_ONE;
        end else if (up_ff) begin
          nxt_counter = counter_value_ff + `TMR_ONE;
        end else begin
          nxt_counter = counter_value_ff - `TMR_ONE;
        end
      end else if (clear_at_top && at_top) begin
        nxt_up = 1'b1;
        nxt_counter = `TMR_BOTTOM;
      end else begin
        nxt_up = 1'b1;
        nxt_counter = counter_value_ff + `TMR_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      counter_value_ff <= `TMR_BOTTOM;
      up_ff <= 1'b1;
    end else begin
      counter_value_ff <= nxt_counter;
      up_ff <= nxt_up;
    end
  end

  // Flag rises as the counter wraps to zero in normal mode or clears at top in CTC and fast PWM; set beats acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag_ff <= 1'b0;
    end else if (!counter_write && timer_tick && wrap && !clear_at_top) begin
      overflow_flag_ff <= 1'b1;
    end else if (!counter_write && timer_tick && clear_at_top && at_top && wave_class != timer16_pkg::WAVE_PHASE) begin
      overflow_flag_ff <= 1'b1;
    end else if (overflow_ack) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `TMR_NCH; gi = gi + 1) begin : g_chan
      logic force_ok;
      logic pwm_set;
      logic pwm_clr;
      assign match[gi] = timer_tick && !counter_write && (counter_value_ff == cmp_val[gi]);
      assign force_ok = force_chan[gi] && (wave_class == timer16_pkg::WAVE_NONPWM);
      assign pwm_set = timer_tick && ((wave_class == timer16_pkg::WAVE_FAST && counter_value_ff == cnt_top) ||
                       (wave_class == timer16_pkg::WAVE_PHASE && up_ff == 1'b0 && counter_value_ff == cmp_val[gi]));
      assign pwm_clr = timer_tick && (counter_value_ff == cmp_val[gi]) && !(wave_class == timer16_pkg::WAVE_PHASE && !up_ff);

      // Mode is sampled live, so a change first acts at the next match, force strobe or fast PWM top
      compare_output_channel u_chan (
        .clk(clk),
        .rst(rst),
        .compare_output_mode(cmp_mode[gi]),
        .match(match[gi]),
        .force_strobe(force_ok),
        .pwm_set(pwm_set),
        .pwm_clr(pwm_clr),
        .wave_class(wave_class),
        .pin_ff(pin[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      compare_match_ff <= `TMR_MATCH_NONE;
    end else begin
      compare_match_ff <= match;
    end
  end

  assign compare_output_pin_ff = pin;

endmodule : timer16

// *** sim/timer16_asserts.sv ***
// Checker for the 16-bit timer: counting, overflow flag and channel A output.
// Assumes a bind to timer16, with all ports synchronous to clk.
`timescale 1ns/1ps
module timer16_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic timer_tick,
  input wire logic [3:0] waveform_gen_mode,
  input wire timer16_pkg::chan_cfg_s chan_a,
  input wire logic counter_write,
  input wire logic [15:0] counter_wdata,
  input wire logic overflow_ack,
  input wire logic [15:0] counter_value_ff,
  input wire logic overflow_flag_ff,
  input wire logic [1:0] compare_match_ff,
  input wire logic [1:0] compare_output_pin_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire step = timer_tick && !counter_write && waveform_gen_mode == 4'h0;
  wire at_max = counter_value_ff == 16'hFFFF;
  sequence s_pulse;
    compare_match_ff[0] ##1 !compare_match_ff[0];
  endsequence
  property p_inc; step |=> counter_value_ff == 16'($past(counter_value_ff) + 16'h0001); endproperty
  property p_hold; !timer_tick && !counter_write |=> $stable(counter_value_ff); endproperty
  property p_load; counter_write |=> counter_value_ff == $past(counter_wdata); endproperty
  property p_wrap; step && at_max |=> overflow_flag_ff && counter_value_ff == 16'h0000; endproperty
  property p_keep; overflow_flag_ff && !overflow_ack |=> overflow_flag_ff; endproperty
  property p_noset; waveform_gen_mode == 4'h0 && !overflow_flag_ff && !(step && at_max) |=> !overflow_flag_ff;
  endproperty
  property p_none; chan_a.compare_output_mode == 2'h0 |=> $stable(compare_output_pin_ff[0]); endproperty
  property p_tog; step && chan_a.compare_output_mode == 2'h1 && !chan_a.force_compare_strobe
    && counter_value_ff == chan_a.compare_value |=> (compare_output_pin_ff[0] != $past(compare_output_pin_ff[0]))
    ##0 s_pulse; endproperty
  property p_force; chan_a.force_compare_strobe && chan_a.compare_output_mode == 2'h3
    && waveform_gen_mode == 4'h0 |=> compare_output_pin_ff[0]; endproperty
  property p_pwm_force; chan_a.force_compare_strobe && !timer_tick && waveform_gen_mode[2:0] == 3'h5
    |=> $stable(compare_output_pin_ff[0]); endproperty
  a_inc: assert property (p_inc) else $error("counter missed a step");
  a_hold: assert property (p_hold) else $error("counter moved without tick");
  a_load: assert property (p_load) else $error("counter write lost");
  a_wrap: assert property (p_wrap) else $error("wrap or flag wrong");
  a_keep: assert property (p_keep) else $error("flag cleared by counting");
  a_noset: assert property (p_noset) else $error("flag set without wrap");
  a_none: assert property (p_none) else $error("pin moved in mode zero");
  a_tog: assert property (p_tog) else $error("match toggle wrong");
  a_force: assert property (p_force) else $error("force did not set pin");
  a_pwm_force: assert property (p_pwm_force) else $error("force acted in PWM mode");
endmodule : timer16_asserts

bind timer16 timer16_asserts u_chk (.clk(clk), .rst(rst), .timer_tick(timer_tick),
  .waveform_gen_mode(waveform_gen_mode), .chan_a(chan_a), .counter_write(counter_write),
  .counter_wdata(counter_wdata), .overflow_ack(overflow_ack), .counter_value_ff(counter_value_ff),
  .overflow_flag_ff(overflow_flag_ff), .compare_match_ff(compare_match_ff),
  .compare_output_pin_ff(compare_output_pin_ff));

// *** sim/timer16_tb.sv ***
// Testbench for timer16 in normal and fast PWM modes; both channels share one configuration.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module timer16_tb;
  logic clk, rst, tick, wr, ack, f, p;
  logic [3:0] wgm;
  logic [15:0] wd, top, c, cv;
  logic of;
  logic [1:0] cm, op;
  timer16_pkg::chan_cfg_s ca;
  logic [18:0] q[$];
  logic [18:0] e;
  int miscompares, num_checks;
  timer16 u_dut (.clk(clk), .rst(rst), .timer_tick(tick), .waveform_gen_mode(wgm), .chan_a(ca),
    .chan_b(ca), .top_value(top), .counter_write(wr), .counter_wdata(wd), .overflow_ack(ack),
    .counter_value_ff(cv), .overflow_flag_ff(of), .compare_match_ff(cm), .compare_output_pin_ff(op));
  task end_of_test;
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // Drives one cycle and notes the expected state after the next edge
  task cyc(input logic t, w, a, input logic [15:0] d);
    logic m;
    tick = t;
    wr = w;
    ack = a;
    wd = d;
    m = t && !w && c == ca.compare_value;
    if (wgm != 4'h0) begin
      if (ca.compare_output_mode[1] && t && c == top) p = !ca.compare_output_mode[0];
      else if (ca.compare_output_mode[1] && t && c == ca.compare_value) p = ca.compare_output_mode[0];
    end else if (m || ca.force_compare_strobe) case (ca.compare_output_mode)
      2'h1: p = !p;
      2'h2: p = 1'b0;
      2'h3: p = 1'b1;
      default: ;
    endcase
    if (a) f = 1'b0;
    if (w) c = d;
    else if (t) begin
      if (wgm != 4'h0 && c == top) begin
        c = 16'h0000;
        f = 1'b1;
      end else begin
        if (wgm == 4'h0 && c == 16'hFFFF) f = 1'b1;
        c = c + 16'h0001;
      end
    end
    // Noted at the edge so the watcher pairs it with the outputs of this edge
    @(posedge clk);
    q.push_back({c, f, m, p});
    #1;
  endtask : cyc
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial forever begin
    @(posedge clk);
    #2;
    if (q.size() > 0) begin
      e = q.pop_front();
      num_checks++;
      if ({cv, of, cm[0], op[0]} !== e || cm[1] !== cm[0] || op[1] !== op[0]) begin
        $display("[ERR] %0t got %h %b %b %b exp %h", $time, cv, of, cm, op, e);
        miscompares++;
      end
    end
  end
  initial begin
    #40000;
    miscompares++;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    {tick, wr, ack, f, p} = 5'h00;
    wd = 16'h0000;
    c = 16'h0000;
    wgm = 4'h0;
    top = 16'hFFFF;
    ca = '0;
    void'($urandom(21059));
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    cyc(1'b0, 1'b0, 1'b0, 16'h0000);
    cyc(1'b1, 1'b1, 1'b0, 16'hFFFE);
    repeat (3) cyc(1'b1, 1'b0, 1'b0, 16'h0000);
    cyc(1'b0, 1'b0, 1'b1, 16'h0000);
    cyc(1'b0, 1'b1, 1'b0, 16'hFFFF);
    cyc(1'b1, 1'b0, 1'b1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      ca.compare_output_mode = 2'(i);
      ca.compare_value = 16'h0010;
      cyc(1'b0, 1'b1, 1'b0, 16'h000F);
      repeat (2) cyc(1'b1, 1'b0, 1'b0, 16'h0000);
      ca.force_compare_strobe = 1'b1;
      cyc(1'b0, 1'b0, 1'b0, 16'h0000);
      ca.force_compare_strobe = 1'b0;
    end
    // Fast PWM with top just above the compare value; force must be ignored
    wgm = 4'h5;
    top = 16'h0012;
    ca.compare_value = 16'h0010;
    for (int i = 2; i < 4; i++) begin
      ca.compare_output_mode = 2'(i);
      cyc(1'b0, 1'b1, 1'b0, 16'h000F);
      repeat (5) cyc(1'b1, 1'b0, 1'b0, 16'h0000);
      ca.force_compare_strobe = 1'b1;
      cyc(1'b0, 1'b0, 1'b1, 16'h0000);
      ca.force_compare_strobe = 1'b0;
    end
    wgm = 4'h0;
    top = 16'hFFFF;
    repeat (300) begin
      ca.compare_output_mode = 2'($urandom);
      ca.compare_value = c + 16'($urandom_range(3));
      cyc(1'($urandom), $urandom_range(15) == 0, $urandom_range(7) == 0, {12'hFFF, 4'($urandom)});
    end
    repeat (2) @(posedge clk);
    end_of_test;
  end
endmodule : timer16_tb
